// ### scsb_params.svh
// Register offsets, field positions, reset values and boot counts of the clock block.
`ifndef SCSB_PARAMS_SVH
`define SCSB_PARAMS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SCSB_OFF_CLOCK_MODE 8'h00
`define SCSB_OFF_CRYSTAL_CTRL 8'h04
`define SCSB_OFF_FAST_RC_TRIM 8'h08
`define SCSB_OFF_BOOT_STATUS 8'h0C
`define SCSB_OFF_SYSTEM_CTRL 8'h10

// ----------------------------------------
// Field positions
// ----------------------------------------
`define SCSB_CM_FAST_EN 4
`define SCSB_CM_SLOW_EN 2
`define SCSB_XTAL_EN 7
`define SCSB_SC_WATCHDOG 0
`define SCSB_SC_PIN5_INPUT 1

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SCSB_RST_CLOCK_MODE 8'hF4
`define SCSB_RST_CRYSTAL_CTRL 8'h00
`define SCSB_RST_FAST_RC_TRIM 8'h80
`define SCSB_RST_SYSTEM_CTRL 8'h03

// ----------------------------------------
// Boot-time clock mode values
// ----------------------------------------
`define SCSB_CM_FAST_DIV2 8'h34
`define SCSB_CM_FAST_DIV4 8'h14
`define SCSB_CM_FAST_DIV8 8'h3C
`define SCSB_CM_FAST_DIV16 8'h1C
`define SCSB_CM_FAST_DIV32 8'h7C
`define SCSB_CM_SLOW_DIV1 8'hE4

// ----------------------------------------
// Boot delay in slow RC cycles
// ----------------------------------------
`define SCSB_BOOT_FAST_CYCLES 12'h02D
`define SCSB_BOOT_NORMAL_CYCLES 12'hBB8

`endif

// ### scsb_pkg.sv
// Types shared by the clock select and boot block.
package scsb_pkg;

	typedef enum logic [1:0] {
		SRC_FAST = 2'b00,
		SRC_SLOW = 2'b01,
		SRC_XTAL = 2'b10
	} scsb_src_type;

	typedef enum logic [2:0] {
		CAL_DISABLE = 3'b000,
		CAL_DIV2 = 3'b001,
		CAL_DIV4 = 3'b010,
		CAL_DIV8 = 3'b011,
		CAL_DIV16 = 3'b100,
		CAL_DIV32 = 3'b101,
		CAL_SLOW = 3'b110
	} scsb_cal_type;

	typedef enum logic [1:0] {
		ST_BOOT = 2'b00,
		ST_CALIB = 2'b01,
		ST_RUN = 2'b10
	} scsb_state_type;

	// Clock source plus divide ratio as a power of two.
	typedef struct packed {
		scsb_src_type src;
		logic [2:0] div_log;
	} scsb_sel_type;

endpackage

// ### scsb_clock_select.sv
// System clock source selection, divider and power-on boot sequencing.
//
// Overview of operation
// - The crystal, fast RC and slow RC oscillators have separate enables and run independently.
// - When boot completes the slow RC is running, and the fast RC too unless calibration applies clock mode E4h.
// - After reset execution is held for 45 (fast) or 3000 (normal) slow RC cycles.
// - Clock mode 34h, 14h and 3Ch select the fast RC divided by 2, 4 and 8.
// - Clock mode 1Ch and 7Ch select the fast RC divided by 16 and 32.
// - Clock mode E4h selects the undivided slow RC with fast RC stopped; applied by calibration it also leaves the watchdog running.
// - The fast RC frequency follows a trim value loaded by calibration, nominally 16 MHz.
// - With calibration disabled, clock mode and trim keep their boot values.
// - After a calibrated divided fast RC boot the watchdog is off, slow RC on, pin 5 an input.
// - A clock mode write switches the system clock only when a low phase of the current system clock ends.
`timescale 1ns/1ns
`include "scsb_params.svh"

module scsb_clock_select
	import scsb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fast_rc_clk,
	input wire logic slow_rc_clk,
	input wire logic crystal_clk,
	input wire logic fast_boot,
	input wire logic [2:0] calibration_directive,
	input wire logic [7:0] calibration_trim,
	output logic fast_rc_oscillator_en,
	output logic slow_rc_oscillator_en,
	output logic crystal_oscillator_en,
	output logic [7:0] fast_rc_trim,
	output logic sys_clk,
	output logic cpu_run,
	output logic watchdog_en,
	output logic port_a_pin5_input
);

	// ----------------------------------------
	// Helper functions
	// ----------------------------------------
	// Map a clock mode value to source and divider; unlisted codes give fast RC / 64.
	function automatic scsb_sel_type sel_decode(input logic [7:0] m);
		scsb_sel_type s;
		s.src = SRC_FAST;
		s.div_log = 3'd6;
		case ({m[7:5], m[3]})
			4'b0010: s.div_log = 3'd1;
			4'b0000: s.div_log = 3'd2;
			4'b0011: s.div_log = 3'd3;
			4'b0001: s.div_log = 3'd4;
			4'b0111: s.div_log = 3'd5;
			4'b1110: begin
				s.src = SRC_SLOW;
				s.div_log = 3'd0;
			end
			4'b1010: begin
				s.src = SRC_XTAL;
				s.div_log = 3'd0;
			end
			default: s.div_log = 3'd6;
		endcase
		return s;
	endfunction

	// Last count of a half period, in source rising edges.
	function automatic logic [4:0] half_last(input logic [2:0] lg);
		logic [6:0] h;
		h = 7'd1 << lg;
		return 5'(h[6:1] - 6'd1);
	endfunction

	// Clock mode value applied at the end of boot for each calibration option.
	function automatic logic [7:0] cal_mode(input scsb_cal_type c);
		case (c)
			CAL_DIV2: cal_mode = `SCSB_CM_FAST_DIV2;
			CAL_DIV4: cal_mode = `SCSB_CM_FAST_DIV4;
			CAL_DIV8: cal_mode = `SCSB_CM_FAST_DIV8;
			CAL_DIV16: cal_mode = `SCSB_CM_FAST_DIV16;
			CAL_DIV32: cal_mode = `SCSB_CM_FAST_DIV32;
			CAL_SLOW: cal_mode = `SCSB_CM_SLOW_DIV1;
			default: cal_mode = `SCSB_RST_CLOCK_MODE;
		endcase
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] clock_mode_q;
	logic [7:0] crystal_ctrl_q;
	logic [7:0] trim_q;
	logic [7:0] system_ctrl_q;
	logic [31:0] prdata_q;
	scsb_state_type state_q;
	logic [11:0] boot_cnt_q;
	logic boot_fast_q;
	logic armed_q;
	scsb_cal_type cal_q;
	logic run_q;
	logic [2:0] prev_q;
	scsb_sel_type act_q;
	logic [4:0] div_cnt_q;
	logic sys_clk_q;

	logic wr_en;
	logic rd_setup;
	logic addr_ok;
	logic [7:0] offs;
	logic [31:0] rd_mux;
	logic calib_apply;
	logic [2:0] src_vec;
	logic src_now;
	logic src_rise;
	logic slow_rise;
	logic boot_end;
	logic [11:0] boot_last;
	logic boundary;
	scsb_sel_type sel_pend;

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	assign offs = paddr[7:0];
	assign addr_ok = (paddr[31:8] == 24'h00_0000) &&
		(offs == `SCSB_OFF_CLOCK_MODE || offs == `SCSB_OFF_CRYSTAL_CTRL ||
		offs == `SCSB_OFF_FAST_RC_TRIM || offs == `SCSB_OFF_BOOT_STATUS ||
		offs == `SCSB_OFF_SYSTEM_CTRL);
	assign wr_en = psel && penable && pwrite && addr_ok;
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_q;

	always_comb begin
		rd_mux = 32'h0000_0000;
		case (offs)
			`SCSB_OFF_CLOCK_MODE: rd_mux[7:0] = clock_mode_q;
			`SCSB_OFF_CRYSTAL_CTRL: rd_mux[7:0] = crystal_ctrl_q;
			`SCSB_OFF_FAST_RC_TRIM: rd_mux[7:0] = trim_q;
			`SCSB_OFF_BOOT_STATUS: rd_mux[7:0] = {1'b0, cal_q, act_q.src, boot_fast_q, run_q};
			`SCSB_OFF_SYSTEM_CTRL: rd_mux[7:0] = system_ctrl_q;
			default: rd_mux = 32'h0000_0000;
		endcase
		if (paddr[31:8] != 24'h00_0000) begin
			rd_mux = 32'h0000_0000;
		end
	end

	// Read data is captured in the setup phase so the access phase needs no wait.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h0000_0000;
		end else if (rd_setup) begin
			prdata_q <= rd_mux;
		end
	end

	// ----------------------------------------
	// Control registers
	// ----------------------------------------
	assign calib_apply = (state_q == ST_CALIB) && (cal_q != CAL_DISABLE);

	// Boot value keeps both RC oscillators on and the slow RC as source.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clock_mode_q <= `SCSB_RST_CLOCK_MODE;
		end else if (calib_apply) begin
			clock_mode_q <= cal_mode(cal_q);
		end else if (wr_en && offs == `SCSB_OFF_CLOCK_MODE) begin
			clock_mode_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			crystal_ctrl_q <= `SCSB_RST_CRYSTAL_CTRL;
		end else if (wr_en && offs == `SCSB_OFF_CRYSTAL_CTRL) begin
			crystal_ctrl_q <= pwdata[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			trim_q <= `SCSB_RST_FAST_RC_TRIM;
		end else if (calib_apply) begin
			trim_q <= calibration_trim;
		end else if (wr_en && offs == `SCSB_OFF_FAST_RC_TRIM) begin
			trim_q <= pwdata[7:0];
		end
	end

	// Watchdog stays on unless a calibrated fast RC mode is applied or a system control write clears bit 0.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			system_ctrl_q <= `SCSB_RST_SYSTEM_CTRL;
		end else if (calib_apply) begin
			system_ctrl_q[`SCSB_SC_WATCHDOG] <= (cal_q == CAL_SLOW);
			system_ctrl_q[`SCSB_SC_PIN5_INPUT] <= 1'b1;
		end else if (wr_en && offs == `SCSB_OFF_SYSTEM_CTRL) begin
			system_ctrl_q <= {6'h00, pwdata[1:0]};
		end
	end

	assign fast_rc_oscillator_en = clock_mode_q[`SCSB_CM_FAST_EN];
	assign slow_rc_oscillator_en = clock_mode_q[`SCSB_CM_SLOW_EN];
	assign crystal_oscillator_en = crystal_ctrl_q[`SCSB_XTAL_EN];
	assign fast_rc_trim = trim_q;
	assign watchdog_en = system_ctrl_q[`SCSB_SC_WATCHDOG];
	assign port_a_pin5_input = system_ctrl_q[`SCSB_SC_PIN5_INPUT];

	// ----------------------------------------
	// Boot sequencer
	// ----------------------------------------
	assign src_vec = {crystal_clk, slow_rc_clk, fast_rc_clk};
	assign slow_rise = slow_rc_clk && !prev_q[1];
	assign boot_last = (boot_fast_q ? `SCSB_BOOT_FAST_CYCLES : `SCSB_BOOT_NORMAL_CYCLES) - 12'd1;
	assign boot_end = armed_q && slow_rise && (boot_cnt_q == boot_last);

	// Boot straps are caught on the first clock after reset release.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			armed_q <= 1'b0;
			boot_fast_q <= 1'b0;
			cal_q <= CAL_DISABLE;
		end else if (!armed_q) begin
			armed_q <= 1'b1;
			boot_fast_q <= fast_boot;
			cal_q <= scsb_cal_type'(calibration_directive);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_BOOT;
			boot_cnt_q <= 12'h000;
		end else begin
			case (state_q)
				ST_BOOT: begin
					if (boot_end) begin
						state_q <= ST_CALIB;
					end else if (armed_q && slow_rise) begin
						boot_cnt_q <= boot_cnt_q + 12'd1;
					end
				end
				ST_CALIB: state_q <= ST_RUN;
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_BOOT;
			endcase
		end
	end

	// Execution is released on the same clock edge on which the calibration settings land.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_q <= 1'b0;
		end else begin
			run_q <= (state_q == ST_CALIB) || (state_q == ST_RUN);
		end
	end

	assign cpu_run = run_q;

	// ----------------------------------------
	// System clock generator
	// ----------------------------------------
	assign sel_pend = sel_decode(clock_mode_q);
	assign src_now = src_vec[act_q.src];
	assign src_rise = src_now && !prev_q[act_q.src];
	// A new period may only begin while the output is low and a period ends.
	assign boundary = src_rise && !sys_clk_q &&
		((act_q.div_log == 3'd0) || (div_cnt_q == half_last(act_q.div_log)));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 3'b000;
		end else begin
			prev_q <= src_vec;
		end
	end

	// A switch only stretches the low phase; it never cuts a high or low phase short.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// The reset clock mode selects the undivided slow RC.
			act_q.src <= SRC_SLOW;
			act_q.div_log <= 3'd0;
			div_cnt_q <= 5'd0;
			sys_clk_q <= 1'b0;
		end else if (boundary && sel_pend != act_q) begin
			act_q <= sel_pend;
			div_cnt_q <= 5'd0;
			sys_clk_q <= 1'b0;
		end else if (act_q.div_log == 3'd0) begin
			// Undivided: high from a seen rising edge until the source falls.
			if (src_rise) begin
				sys_clk_q <= 1'b1;
			end else if (!src_now) begin
				sys_clk_q <= 1'b0;
			end
		end else if (src_rise) begin
			if (div_cnt_q == half_last(act_q.div_log)) begin
				div_cnt_q <= 5'd0;
				sys_clk_q <= !sys_clk_q;
			end else begin
				div_cnt_q <= div_cnt_q + 5'd1;
			end
		end
	end

	assign sys_clk = sys_clk_q;

endmodule

// ### scsb_clock_select_monitor.sv
// Port checker of the clock select and boot block.
`timescale 1ns/1ns
`include "scsb_params.svh"
module scsb_monitor
	import scsb_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pslverr,
	input wire logic slow_rc_clk,
	input wire logic fast_boot,
	input wire logic [2:0] calibration_directive,
	input wire logic [7:0] calibration_trim,
	input wire logic fast_rc_oscillator_en,
	input wire logic slow_rc_oscillator_en,
	input wire logic crystal_oscillator_en,
	input wire logic [7:0] fast_rc_trim,
	input wire logic cpu_run,
	input wire logic watchdog_en,
	input wire logic port_a_pin5_input
);
	logic [15:0] rise_q;
	logic slow_q;
	logic [15:0] boot_n;
	logic cal_off;
	assign boot_n = fast_boot ? 16'(`SCSB_BOOT_FAST_CYCLES) : 16'(`SCSB_BOOT_NORMAL_CYCLES);
	assign cal_off = calibration_directive == CAL_DISABLE;
	// ----
	// Slow oscillator rising edges since reset.
	// ----
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rise_q <= 16'h0000;
			slow_q <= 1'b0;
		end else begin
			slow_q <= slow_rc_clk;
			if (slow_rc_clk && !slow_q) begin
				rise_q <= rise_q + 16'h0001;
			end
		end
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	fast_slow_en_a: assert property (psel && penable && pwrite && paddr == 32'h0 |=>
		fast_rc_oscillator_en == $past(pwdata[4]) && slow_rc_oscillator_en == $past(pwdata[2]))
		else $error("rc enables do not follow write");
	crystal_en_a: assert property (psel && penable && pwrite && paddr == 32'h4 |=>
		crystal_oscillator_en == $past(pwdata[7])) else $error("crystal enable wrong");
	boot_len_a: assert property ($rose(cpu_run) |->
		rise_q >= boot_n && rise_q <= boot_n + 16'h0003) else $error("boot delay wrong");
	run_hold_a: assert property (cpu_run |=> cpu_run) else $error("cpu_run dropped");
	boot_osc_a: assert property ($rose(cpu_run) |-> slow_rc_oscillator_en &&
		fast_rc_oscillator_en == (calibration_directive != CAL_SLOW)) else $error("boot osc");
	boot_wdog_a: assert property ($rose(cpu_run) |-> port_a_pin5_input &&
		watchdog_en == (cal_off || calibration_directive == CAL_SLOW)) else $error("boot wdog");
	boot_trim_a: assert property ($rose(cpu_run) |-> fast_rc_trim ==
		(cal_off ? `SCSB_RST_FAST_RC_TRIM : calibration_trim)) else $error("boot trim");
	err_scope_a: assert property (!(psel && penable) |-> !pslverr) else $error("stray pslverr");
	unmapped_err_a: assert property (psel && penable && paddr[31:8] != 24'h0 |-> pslverr)
		else $error("no pslverr");
endmodule
bind scsb_clock_select scsb_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
	.slow_rc_clk(slow_rc_clk), .fast_boot(fast_boot),
	.calibration_directive(calibration_directive), .calibration_trim(calibration_trim),
	.fast_rc_oscillator_en(fast_rc_oscillator_en), .slow_rc_oscillator_en(slow_rc_oscillator_en),
	.crystal_oscillator_en(crystal_oscillator_en), .fast_rc_trim(fast_rc_trim),
	.cpu_run(cpu_run), .watchdog_en(watchdog_en), .port_a_pin5_input(port_a_pin5_input));

// ### test_system_clock_select_boot.sv
// Testbench of the clock select and boot block.
`timescale 1ns/1ns
module test_system_clock_select_boot
	import scsb_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0000_0000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic fast_rc_clk = 1'b0;
	logic slow_rc_clk = 1'b0;
	logic crystal_clk = 1'b0;
	logic fast_boot = 1'b0;
	logic [2:0] cal = 3'h0;
	logic [7:0] trim = 8'h00;
	logic [3:0] cyc = 4'h0;
	logic [31:0] prdata, rdat;
	logic [7:0] ftrim;
	logic pready, pslverr, fen, sen, xen, sys_clk, cpu_run, wd, pin5, rerr;
	logic [7:0] cm [7] = '{8'hF4, 8'h34, 8'h14, 8'h3C, 8'h1C, 8'h7C, 8'hE4};
	int dv [7] = '{1, 2, 4, 8, 16, 32, 1};
	logic [7:0] sc [5] = '{8'hF4, 8'hA6, 8'h34, 8'h30, 8'h54};
	int sp [5] = '{4, 8, 8, 8, 256};
	int err_count = 0;
	int comparisons = 0;
	always #5 pclk = ~pclk;
	// ----
	// Oscillators run only while enabled.
	// ----
	always @(posedge pclk) begin
		cyc <= cyc + 4'h1;
		fast_rc_clk <= fen & cyc[1];
		slow_rc_clk <= sen & presetn & cyc[1];
		crystal_clk <= xen & cyc[2];
	end
	scsb_clock_select DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fast_rc_clk(fast_rc_clk), .slow_rc_clk(slow_rc_clk),
		.crystal_clk(crystal_clk), .fast_boot(fast_boot), .calibration_directive(cal),
		.calibration_trim(trim), .fast_rc_oscillator_en(fen), .slow_rc_oscillator_en(sen),
		.crystal_oscillator_en(xen), .fast_rc_trim(ftrim), .sys_clk(sys_clk),
		.cpu_run(cpu_run), .watchdog_en(wd), .port_a_pin5_input(pin5));
	task end_sim;
		$display("comparisons %0d errors %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
		comparisons++;
		if (got !== ex) begin
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
			err_count++;
		end
	endtask
	task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] ex, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, ex, rdat);
	endtask
	task period(input int ex);
		int n;
		logic p;
		repeat (3) begin
			n = 0;
			do begin
				p = sys_clk;
				@(posedge pclk);
				n++;
			end while (!(p === 1'b0 && sys_clk === 1'b1) && n < 400);
		end
		chk("sys_clk period", 32'(ex), 32'(n));
	endtask
	initial begin
		#400000;
		err_count++;
		end_sim;
	end
	initial begin
		time t0;
		int nb;
		int bn;
		for (int o = 0; o < 7; o++) begin
			presetn <= 1'b0;
			fast_boot <= (o != 0);
			cal <= 3'(o);
			trim <= 8'h40 + 8'(o);
			repeat (3) @(posedge pclk);
			presetn <= 1'b1;
			t0 = $time;
			bn = (o != 0) ? 45 : 3000;
			if (o == 0) begin
				rd(32'h0, 32'hF4, "clock mode reset");
				rd(32'h4, 32'h00, "crystal reset");
				rd(32'h8, 32'h80, "trim reset");
				rd(32'h10, 32'h03, "system reset");
				rd(32'h100, 32'h0, "unmapped read");
				chk("unmapped err", 32'h1, 32'(rerr));
			end
			nb = 0;
			while (cpu_run !== 1'b1 && nb < 13000) begin
				@(posedge pclk);
				nb++;
			end
			nb = int'(($time - t0) / 10);
			chk("boot length", 32'h1, 32'(nb >= 4 * bn - 4 && nb <= 4 * bn + 16));
			rd(32'h0, 32'(cm[o]), "clock mode");
			rd(32'h8, (o == 0) ? 32'h80 : 32'(8'h40 + 8'(o)), "trim");
			rd(32'h10, (o == 0 || o == 6) ? 32'h3 : 32'h2, "system ctrl");
			chk("watchdog pin", (o == 0 || o == 6) ? 32'h1 : 32'h0, 32'(wd));
			chk("pin5 input pin", 32'h1, 32'(pin5));
			chk("trim pin", (o == 0) ? 32'h80 : 32'(8'h40 + 8'(o)), 32'(ftrim));
			rd(32'hC, 32'(o * 16 + ((o == 0 || o == 6) ? 4 : 0) + ((o != 0) ? 2 : 0) + 1),
				"boot status");
			chk("fast en", 32'(cm[o][4]), 32'(fen));
			chk("slow en", 32'h1, 32'(sen));
			period(4 * dv[o]);
		end
		apb(1'b1, 32'h4, 32'h80);
		chk("crystal en", 32'h1, 32'(xen));
		for (int i = 0; i < 5; i++) begin
			apb(1'b1, 32'h0, 32'(sc[i]));
			chk("fast en", 32'(sc[i][4]), 32'(fen));
			chk("slow en", 32'(sc[i][2]), 32'(sen));
			period(sp[i]);
		end
		apb(1'b1, 32'hC, 32'hFF);
		rd(32'hC, 32'h63, "boot status ro");
		apb(1'b1, 32'h14, 32'h0);
		chk("unmapped write err", 32'h1, 32'(rerr));
		end_sim;
	end
endmodule
